// ==== pkg/asp_pkg.sv ====
package asp_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int CNT_W  = 8;
    localparam int DIV_W  = 8;
    localparam int PIN_N  = 9;
    // Positions of the synchronised pin inputs.
    localparam int PIN_SER   = 0;
    localparam int PIN_EXT   = 1;
    localparam int PIN_CHAIN = 2;
    localparam int PIN_SCLK  = 3;
    localparam int PIN_INV   = 4;
    localparam int PIN_FMT   = 5;
    localparam int PIN_POL   = 6;
    localparam int PIN_CSN   = 7;
    localparam int PIN_RDN   = 8;
    localparam logic [PIN_N-1:0] PIN_RST = 9'h180;
    // Result bits that share the serial pins in parallel mode.
    localparam int PAR_BIT_CHAIN = 7;
    localparam int PAR_BIT_SDO   = 8;
    localparam int PAR_BIT_SCLK  = 9;
    localparam int PAR_BIT_SYNC  = 10;
    // Register byte addresses.
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h08;
    localparam logic [DIV_W-1:0]  DIV_RST     = 8'h03;
    localparam logic [1:0]        RESP_OKAY   = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;
    localparam logic [CNT_W-1:0]  LAST_BIT    = 8'h0F;
    localparam logic [CNT_W-1:0]  CNT_MAX     = 8'hFF;
    localparam logic [1:0]        PHASE_HIGH  = 2'h1;
    localparam logic [1:0]        PHASE_LAST  = 2'h2;
    localparam logic [DATA_W-1:0] MSB_MASK    = 16'h8000;
    typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} asp_state_t;
endpackage

// ==== design/asp_pair_buffer.sv ====
`timescale 1ns/100ps
`default_nettype none
module asp_pair_buffer #(
    parameter int WIDTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             in_ready,
    output var  logic             out_valid,
    output var  logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic             wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [1:0]       count_reg, count_next;
    logic             ready_reg, ready_next;
    logic             push, pop;

    always_comb begin
        push        = in_valid && ready_reg;
        pop         = out_ready && (count_reg != 2'h0);
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next          = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        count_next = count_reg + {1'b0, push} - {1'b0, pop};
        ready_next = (count_next != 2'h2);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            ready_reg  <= 1'b0;
        end else begin
            mem_reg    <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            ready_reg  <= ready_next;
        end
    end

    assign in_ready  = ready_reg;
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];
endmodule // asp_pair_buffer
`default_nettype wire

// ==== design/asp_serial_port.sv ====
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module asp_serial_port (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [asp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output var  logic                       s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output var  logic                       s_axi_wready,
    output var  logic [1:0]                 s_axi_bresp,
    output var  logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [asp_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output var  logic                       s_axi_arready,
    output var  logic [31:0]                s_axi_rdata,
    output var  logic [1:0]                 s_axi_rresp,
    output var  logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       result_valid,
    input  wire logic [asp_pkg::DATA_W-1:0] result_data,
    output var  logic                       result_ready,
    input  wire logic                       conversion_busy,
    input  wire logic                       serial_select,
    input  wire logic                       external_clock_select,
    input  wire logic                       clock_invert_select,
    input  wire logic                       binary_format_select,
    input  wire logic                       frame_polarity_select,
    input  wire logic                       chip_select_n,
    input  wire logic                       read_strobe_n,
    input  wire logic                       read_mode_or_chain_input,
    output var  logic                       chain_pin_out,
    output var  logic                       chain_pin_oe,
    output var  logic                       serial_data_out,
    output var  logic                       serial_data_oe,
    input  wire logic                       serial_clock_pin_in,
    output var  logic                       serial_clock_pin_out,
    output var  logic                       serial_clock_pin_oe,
    output var  logic                       frame_sync_out,
    output var  logic                       frame_sync_oe
);
    localparam int DW = asp_pkg::DATA_W;
    logic [asp_pkg::PIN_N-1:0] pin_raw, sync1_reg, s;
    logic                      s_ser, s_ext, s_chain, s_inv, s_fmt, s_pol, enable_n;
    logic                      sclk_prev_reg, upd_edge;
    asp_pkg::asp_state_t       state_reg, state_next;
    logic [DW-1:0]             shift_reg, shift_next, result_reg, result_next, par_reg, par_next;
    logic [DW-1:0]             fmt_word, buf_data;
    logic [asp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [asp_pkg::DIV_W-1:0] div_cnt_reg, div_cnt_next, ctrl_div_reg, ctrl_div_next;
    logic [1:0]                phase_reg, phase_next;
    logic                      buf_valid, buf_pop, load, start_ok, abort;
    logic [7:0]                pins_reg, pins_next;
    assign pin_raw = {read_strobe_n, chip_select_n, frame_polarity_select, binary_format_select,
                      clock_invert_select, serial_clock_pin_in, read_mode_or_chain_input,
                      external_clock_select, serial_select};
    // Two-stage synchroniser for every pin input.
    for (genvar i = 0; i < asp_pkg::PIN_N; i++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync1_reg[i] <= asp_pkg::PIN_RST[i];
                s[i]         <= asp_pkg::PIN_RST[i];
            end else begin
                sync1_reg[i] <= pin_raw[i];
                s[i]         <= sync1_reg[i];
            end
        end
    end
    assign s_ser    = s[asp_pkg::PIN_SER];
    assign s_ext    = s[asp_pkg::PIN_EXT];
    assign s_chain  = s[asp_pkg::PIN_CHAIN];
    assign s_inv    = s[asp_pkg::PIN_INV];
    assign s_fmt    = s[asp_pkg::PIN_FMT];
    assign s_pol    = s[asp_pkg::PIN_POL];
    assign enable_n = s[asp_pkg::PIN_CSN] || s[asp_pkg::PIN_RDN];
    assign upd_edge = s_inv ? (sclk_prev_reg && !s[asp_pkg::PIN_SCLK])
                            : (!sclk_prev_reg && s[asp_pkg::PIN_SCLK]);
    asp_pair_buffer #(
        .WIDTH (DW)
    ) u_buf (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (result_valid),
        .in_data   (result_data),
        .in_ready  (result_ready),
        .out_valid (buf_valid),
        .out_data  (buf_data),
        .out_ready (buf_pop)
    );
    assign fmt_word = buf_data ^ (s_fmt ? '0 : asp_pkg::MSB_MASK);
    assign start_ok = buf_valid && !enable_n && (s_ext || (s_chain == conversion_busy));
    assign abort    = !s_ser || enable_n;
    always_comb begin
        state_next   = state_reg;
        shift_next   = shift_reg;
        cnt_next     = cnt_reg;
        phase_next   = phase_reg;
        div_cnt_next = div_cnt_reg;
        result_next  = result_reg;
        par_next     = par_reg;
        buf_pop      = 1'b0;
        load         = 1'b0;
        case (state_reg)
            asp_pkg::ST_IDLE: begin
                if (!s_ser) begin
                    buf_pop = buf_valid;
                    if (buf_valid) begin
                        par_next = fmt_word;
                    end
                end else if (start_ok) begin
                    buf_pop      = 1'b1;
                    load         = 1'b1;
                    shift_next   = fmt_word;
                    result_next  = fmt_word;
                    cnt_next     = '0;
                    phase_next   = 2'h0;
                    div_cnt_next = '0;
                    state_next   = s_ext ? asp_pkg::ST_SLAVE : asp_pkg::ST_MASTER;
                end
            end
            asp_pkg::ST_MASTER: begin
                if (abort) begin
                    state_next = asp_pkg::ST_IDLE;
                end else if (div_cnt_reg == ctrl_div_reg) begin
                    div_cnt_next = '0;
                    if (phase_reg == asp_pkg::PHASE_LAST) begin
                        phase_next = 2'h0;
                        shift_next = {shift_reg[DW-2:0], 1'b0};
                        cnt_next   = cnt_reg + 8'h01;
                        if (cnt_reg == asp_pkg::LAST_BIT) begin
                            state_next = asp_pkg::ST_IDLE;
                        end
                    end else begin
                        phase_next = phase_reg + 2'h1;
                    end
                end else begin
                    div_cnt_next = div_cnt_reg + 8'h01;
                end
            end
            asp_pkg::ST_SLAVE: begin
                if (abort) begin
                    state_next = asp_pkg::ST_IDLE;
                end else if (upd_edge) begin
                    shift_next = {shift_reg[DW-2:0], s_chain};
                    if (cnt_reg != asp_pkg::CNT_MAX) begin
                        cnt_next = cnt_reg + 8'h01;
                    end
                end
            end
            default: state_next = asp_pkg::ST_IDLE;
        endcase
    end

    // Pin outputs: {sync_oe, sync, sclk_oe, sclk, sdo_oe, sdo, chain_oe, chain}.
    always_comb begin
        pins_next[0] = par_reg[asp_pkg::PAR_BIT_CHAIN];
        pins_next[1] = !s_ser && !enable_n;
        pins_next[2] = s_ser ? shift_reg[DW-1] : par_reg[asp_pkg::PAR_BIT_SDO];
        pins_next[3] = !enable_n;
        pins_next[4] = s_ser ? ((state_reg == asp_pkg::ST_MASTER && phase_reg == asp_pkg::PHASE_HIGH) ^ s_inv)
                             : par_reg[asp_pkg::PAR_BIT_SCLK];
        pins_next[5] = s_ser ? !s_ext : !enable_n;
        pins_next[6] = s_ser ? ((state_reg == asp_pkg::ST_MASTER) ^ s_pol) : par_reg[asp_pkg::PAR_BIT_SYNC];
        pins_next[7] = s_ser ? !s_ext : !enable_n;
    end

    assign chain_pin_out        = pins_reg[0];
    assign chain_pin_oe         = pins_reg[1];
    assign serial_data_out      = pins_reg[2];
    assign serial_data_oe       = pins_reg[3];
    assign serial_clock_pin_out = pins_reg[4];
    assign serial_clock_pin_oe  = pins_reg[5];
    assign frame_sync_out       = pins_reg[6];
    assign frame_sync_oe        = pins_reg[7];

    // Register slave.
    logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0]  awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next, rdata_next;
    logic        wstrb0_reg, wstrb0_next;
    logic        awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
    logic [1:0]  bresp_next, rresp_next;

    always_comb begin
        aw_hold_next  = aw_hold_reg || (s_axi_awvalid && s_axi_awready);
        w_hold_next   = w_hold_reg || (s_axi_wvalid && s_axi_wready);
        awaddr_next   = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_reg;
        wdata_next    = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_reg;
        wstrb0_next   = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : wstrb0_reg;
        bvalid_next   = s_axi_bvalid && !s_axi_bready;
        bresp_next    = s_axi_bresp;
        ctrl_div_next = ctrl_div_reg;
        if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = asp_pkg::RESP_OKAY;
            if (awaddr_reg == asp_pkg::ADDR_CTRL) begin
                if (wstrb0_reg) begin
                    ctrl_div_next = wdata_reg[asp_pkg::DIV_W-1:0];
                end
            end else if (awaddr_reg != asp_pkg::ADDR_STATUS && awaddr_reg != asp_pkg::ADDR_RESULT) begin
                bresp_next = asp_pkg::RESP_SLVERR;
            end
        end
        awready_next = !aw_hold_next && !bvalid_next;
        wready_next  = !w_hold_next && !bvalid_next;
        rvalid_next  = s_axi_rvalid && !s_axi_rready;
        rdata_next   = s_axi_rdata;
        rresp_next   = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = asp_pkg::RESP_OKAY;
            if (s_axi_araddr == asp_pkg::ADDR_CTRL) begin
                rdata_next = {24'h000000, ctrl_div_reg};
            end else if (s_axi_araddr == asp_pkg::ADDR_STATUS) begin
                rdata_next = {21'h000000, buf_valid, state_reg == asp_pkg::ST_SLAVE,
                              state_reg == asp_pkg::ST_MASTER, cnt_reg};
            end else if (s_axi_araddr == asp_pkg::ADDR_RESULT) begin
                rdata_next = {16'h0000, result_reg};
            end else begin
                rdata_next = 32'h00000000;
                rresp_next = asp_pkg::RESP_SLVERR;
            end
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_prev_reg <= 1'b0;
            state_reg     <= asp_pkg::ST_IDLE;
            shift_reg     <= '0;
            result_reg    <= '0;
            par_reg       <= '0;
            cnt_reg       <= '0;
            div_cnt_reg   <= '0;
            phase_reg     <= 2'h0;
            pins_reg      <= 8'h00;
            ctrl_div_reg  <= asp_pkg::DIV_RST;
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h00000000;
            wstrb0_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            sclk_prev_reg <= s[asp_pkg::PIN_SCLK];
            state_reg     <= state_next;
            shift_reg     <= shift_next;
            result_reg    <= result_next;
            par_reg       <= par_next;
            cnt_reg       <= cnt_next;
            div_cnt_reg   <= div_cnt_next;
            phase_reg     <= phase_next;
            pins_reg      <= pins_next;
            ctrl_div_reg  <= ctrl_div_next;
            aw_hold_reg   <= aw_hold_next;
            w_hold_reg    <= w_hold_next;
            awaddr_reg    <= awaddr_next;
            wdata_reg     <= wdata_next;
            wstrb0_reg    <= wstrb0_next;
            s_axi_awready <= awready_next;
            s_axi_wready  <= wready_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_bresp   <= bresp_next;
            s_axi_arready <= arready_next;
            s_axi_rvalid  <= rvalid_next;
            s_axi_rdata   <= rdata_next;
            s_axi_rresp   <= rresp_next;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_par_pins: assert property (!s_ser |=> serial_data_out == $past(par_reg[asp_pkg::PAR_BIT_SDO])
        && chain_pin_out == $past(par_reg[asp_pkg::PAR_BIT_CHAIN])
        && serial_clock_pin_out == $past(par_reg[asp_pkg::PAR_BIT_SCLK]))
        else $error("Parallel bits missing on shared pins.");
    chk_chain_shift: assert property ((state_reg == asp_pkg::ST_SLAVE && upd_edge && !abort)
        |=> shift_reg[0] == $past(s_chain) && shift_reg[DW-1] == $past(shift_reg[DW-2]))
        else $error("Chain input not shifted in.");
    chk_read_during: assert property ((load && !s_ext && s_chain) |-> conversion_busy)
        else $error("Read-during mode started while idle.");
    chk_read_after: assert property ((load && !s_ext && !s_chain) |-> !conversion_busy)
        else $error("Read-after mode started during conversion.");
    chk_serial_data: assert property ((s_ser && !load) |=> serial_data_out == $past(shift_reg[DW-1]))
        else $error("Serial output does not follow shift register.");
    chk_msb_format: assert property (load |=> shift_reg[DW-1] == ($past(buf_data[DW-1]) ^ !$past(s_fmt)))
        else $error("Leading bit coding wrong.");
    chk_master_stable: assert property ((state_reg == asp_pkg::ST_MASTER && phase_reg != 2'h0)
        |-> $stable(shift_reg))
        else $error("Data changed around internal clock edges.");
    chk_slave_edge: assert property ((state_reg == asp_pkg::ST_SLAVE && !upd_edge) |=> $stable(shift_reg))
        else $error("Data changed away from the update edge.");
    chk_sync_level: assert property ((s_ser && !s_ext)
        |=> frame_sync_out == ($past(state_reg == asp_pkg::ST_MASTER) ^ $past(s_pol)))
        else $error("Frame sync level wrong.");
    chk_sclk_dir: assert property (s_ser |=> serial_clock_pin_oe == !$past(s_ext))
        else $error("Serial clock direction wrong.");
    chk_master_len: assert property ((state_reg == asp_pkg::ST_MASTER && cnt_reg == asp_pkg::LAST_BIT
        && phase_reg == asp_pkg::PHASE_LAST && div_cnt_reg == ctrl_div_reg && !abort)
        |=> state_reg == asp_pkg::ST_IDLE && cnt_reg == 8'h10)
        else $error("Internal-clock read length wrong.");
    cov_master_read: cover property (state_reg == asp_pkg::ST_MASTER ##1 state_reg == asp_pkg::ST_IDLE);
    cov_slave_chain: cover property (state_reg == asp_pkg::ST_SLAVE && cnt_reg == 8'h11);
    cov_parallel: cover property (!s_ser && buf_pop);
    cov_buffer_full: cover property (!result_ready);
endmodule // asp_serial_port
`default_nettype wire

// ==== sim/asp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module asp_host_model (
    input  wire logic        start,
    input  wire logic        ext,
    input  wire logic        inv,
    input  wire logic [5:0]  n_bits,
    input  wire logic        sdo,
    input  wire logic        dev_sclk,
    output wire logic        sclk,
    output var  logic [31:0] rx,
    output var  logic        done
);
    logic ph = 1'b0;
    assign sclk = ph ^ inv;
    initial rx = 32'h0;
    initial done = 1'b0;
    // Samples each bit just before the updating edge of the external clock, or on each rising edge of the device clock.
    always @(posedge start) begin
        done = 1'b0;
        // Keeps the link clock edges and the sampling clear of the system clock edges.
        if (ext) #5;
        for (int i = 0; i < n_bits; i++) begin
            if (ext) begin
                #80;
                rx = {rx[30:0], sdo};
                ph = 1'b1;
                #80;
                ph = 1'b0;
            end else begin
                @(posedge dev_sclk);
                rx = {rx[30:0], sdo};
            end
        end
        done = 1'b1;
    end
endmodule // asp_host_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, h_rx;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, result_ready;
    logic result_valid = 0, conversion_busy = 0, serial_select = 0, external_clock_select = 0;
    logic clock_invert_select = 0, binary_format_select = 0, frame_polarity_select = 0;
    logic chip_select_n = 1, read_strobe_n = 1, chain_drv = 0, h_start = 0, h_done;
    logic [15:0] result_data = 16'h0;
    logic [5:0] h_bits = 6'h10;
    logic chain_pin_out, chain_pin_oe, serial_data_out, serial_data_oe, serial_clock_pin_out;
    logic serial_clock_pin_oe, frame_sync_out, frame_sync_oe;
    wire logic h_sclk, sdo_w, read_mode_or_chain_input, serial_clock_pin_in;
    int n_mismatch = 0;
    int comparisons = 0;
    assign read_mode_or_chain_input = chain_pin_oe ? chain_pin_out : chain_drv;
    assign serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : h_sclk;
    assign sdo_w = serial_data_oe ? serial_data_out : ~serial_data_out;
    always #10 aclk = ~aclk;
    asp_serial_port i_asp_serial_port (.*);
    asp_host_model i_asp_host_model (.start(h_start), .ext(external_clock_select), .inv(clock_invert_select),
        .n_bits(h_bits), .sdo(sdo_w), .dev_sclk(serial_clock_pin_in), .sclk(h_sclk), .rx(h_rx), .done(h_done));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Mismatches %0d of %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask
    task automatic push(input logic [15:0] w);
        result_data <= w;
        result_valid <= 1'b1;
        do @(posedge aclk); while (!result_ready);
        result_valid <= 1'b0;
    endtask
    task automatic t_regs;
        axr(asp_pkg::ADDR_CTRL, 32'h3, asp_pkg::RESP_OKAY);
        axw(asp_pkg::ADDR_CTRL, 32'h1, asp_pkg::RESP_OKAY);
        axr(asp_pkg::ADDR_CTRL, 32'h1, asp_pkg::RESP_OKAY);
        axw(8'h0C, 32'h5, asp_pkg::RESP_SLVERR);
        axr(8'h0C, 32'h0, asp_pkg::RESP_SLVERR);
    endtask
    task automatic t_par;
        logic [15:0] w [2] = '{16'h0280, 16'h0100};
        chip_select_n <= 1'b0;
        read_strobe_n <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            push(w[i]);
            cyc(6);
            chk(chain_pin_out, w[i][7]);
            chk(serial_data_out, w[i][8]);
            chk(serial_clock_pin_out, w[i][9]);
            chk(chain_pin_oe, 1'b1);
        end
        chip_select_n <= 1'b1;
        cyc(5);
        chk(serial_data_oe, 1'b0);
    endtask
    task automatic t_int(input logic mode, input logic [15:0] w);
        serial_select <= 1'b1;
        chain_drv <= mode;
        conversion_busy <= 1'b1;
        binary_format_select <= mode;
        frame_polarity_select <= mode;
        cyc(4);
        h_start <= 1'b1;
        chip_select_n <= 1'b0;
        push(w);
        h_start <= 1'b0;
        cyc(10);
        chk(frame_sync_out, 1'b0);
        conversion_busy <= 1'b0;
        cyc(20);
        chk(frame_sync_out, !mode);
        chk(frame_sync_oe, 1'b1);
        do @(posedge aclk); while (!h_done);
        chk(h_rx[15:0], mode ? w : w ^ asp_pkg::MSB_MASK);
        chip_select_n <= 1'b1;
    endtask
    task automatic t_ext;
        external_clock_select <= 1'b1;
        chain_drv <= 1'b1;
        h_bits <= 6'h20;
        push(16'hA5C3);
        cyc(1);
        push(16'h3C5A);
        cyc(3);
        chk(result_ready, 1'b0);
        chk(serial_clock_pin_oe, 1'b0);
        axr(asp_pkg::ADDR_STATUS, 32'h00000410, asp_pkg::RESP_OKAY);
        axr(asp_pkg::ADDR_RESULT, 32'h0000F00D, asp_pkg::RESP_OKAY);
        for (int n = 0; n < 2; n++) begin
            clock_invert_select <= n[0];
            cyc(4);
            chip_select_n <= 1'b0;
            cyc(4);
            h_start <= 1'b1;
            cyc(1);
            h_start <= 1'b0;
            do @(posedge aclk); while (!h_done);
            chk(h_rx, {n ? 16'h3C5A : 16'hA5C3, 16'hFFFF});
            chip_select_n <= 1'b1;
        end
    endtask
    initial begin
        cyc(6);
        aresetn <= 1'b1;
        cyc(2);
        t_regs();
        t_par();
        t_int(1'b0, 16'h1234);
        t_int(1'b1, 16'hF00D);
        t_ext();
        wrap_up();
    end
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
